// ===== design/osts_pkg.sv
// constants shared by the output terminal selector and its code checker
// assumes one 50 MHz clock and a plain register port with one-cycle read latency
package osts_pkg;
    localparam int SEL_W = 16;                   // selection setting width
    localparam int DAT_W = 16;                   // register port data width
    localparam int ADR_W = 4;                    // register port address width
    localparam int VAL_W = 16;                   // analog quantity width

    // register offsets
    localparam logic [ADR_W-1:0] ADDR_COLL_SEL  = 4'h0;
    localparam logic [ADR_W-1:0] ADDR_RELAY_SEL = 4'h1;
    localparam logic [ADR_W-1:0] ADDR_OC_HOLD   = 4'h2;
    localparam logic [ADR_W-1:0] ADDR_UC_HOLD   = 4'h3;
    localparam logic [ADR_W-1:0] ADDR_STATUS    = 4'h4;

    // reset values
    localparam logic [SEL_W-1:0] COLL_SEL_RST  = 16'h0000;
    localparam logic [SEL_W-1:0] RELAY_SEL_RST = 16'h0063;
    localparam logic [DAT_W-1:0] HOLD_RST      = 16'h0000;

    // status bit positions
    localparam int ST_COLL   = 0;
    localparam int ST_RELAY  = 1;
    localparam int ST_TRIP   = 2;
    localparam int ST_REJECT = 3;

    // code ranges and polarity split
    localparam logic [SEL_W-1:0] NEG_OFFSET = 16'h0064;  // 100
    localparam logic [SEL_W-1:0] CODE_LIMIT = 16'h00C8;  // 200
    localparam logic [SEL_W-1:0] NO_FUNC    = 16'h270F;  // 9999

    // indication codes, positive polarity form
    localparam logic [SEL_W-1:0] C_RUN    = 16'h0000;
    localparam logic [SEL_W-1:0] C_SPEED  = 16'h0001;
    localparam logic [SEL_W-1:0] C_STALL  = 16'h0003;
    localparam logic [SEL_W-1:0] C_THRESH = 16'h0004;
    localparam logic [SEL_W-1:0] C_REGEN  = 16'h0007;
    localparam logic [SEL_W-1:0] C_THERM  = 16'h0008;
    localparam logic [SEL_W-1:0] C_READY  = 16'h000B;
    localparam logic [SEL_W-1:0] C_OVERC  = 16'h000C;
    localparam logic [SEL_W-1:0] C_UNDERC = 16'h000D;
    localparam logic [SEL_W-1:0] C_FBLOW  = 16'h000E;
    localparam logic [SEL_W-1:0] C_FBHIGH = 16'h000F;
    localparam logic [SEL_W-1:0] C_LOOPDIR = 16'h0010;
    localparam logic [SEL_W-1:0] C_BLOWER = 16'h0019;
    localparam logic [SEL_W-1:0] C_HEAT   = 16'h001A;
    localparam logic [SEL_W-1:0] C_PLDEC  = 16'h002E;
    localparam logic [SEL_W-1:0] C_LOOPON = 16'h002F;
    localparam logic [SEL_W-1:0] C_RETRY  = 16'h0040;
    localparam logic [SEL_W-1:0] C_PAUSE  = 16'h0046;
    localparam logic [SEL_W-1:0] C_LIFE   = 16'h005A;
    localparam logic [SEL_W-1:0] C_FAULT3 = 16'h005B;
    localparam logic [SEL_W-1:0] C_AVGPLS = 16'h005D;
    localparam logic [SEL_W-1:0] C_MAINT  = 16'h005F;
    localparam logic [SEL_W-1:0] C_REMOTE = 16'h0060;
    localparam logic [SEL_W-1:0] C_ALARM  = 16'h0062;
    localparam logic [SEL_W-1:0] C_FAULT  = 16'h0063;

    // warning thresholds in percent of the limit
    localparam logic [7:0] PCT_FULL = 8'h64;  // 100
    localparam logic [7:0] PCT_WARN = 8'h55;  // 85

    // hold time unit and clock
    localparam int HOLD_UNIT_NS  = 1_000_000;  // hold settings count milliseconds
    localparam int CLK_PERIOD_NS = 20;
endpackage

// ===== design/osts_code_check.sv
// checks a selection code against the permitted list of one terminal
// assumes the caller uses the result in the same cycle as the code
`timescale 1ns/1ns
module osts_code_check #(
    parameter bit IS_RELAY = 1'b0                 // relay terminal refuses the pulse code
) (
    input  wire logic [osts_pkg::SEL_W-1:0] code, // candidate selection code
    output logic                            valid // code may be stored
);
    import osts_pkg::*;

    logic [SEL_W-1:0] base;

    always_comb begin
        base  = (code >= NEG_OFFSET) ? code - NEG_OFFSET : code;
        valid = 1'b0;
        if (code == NO_FUNC) begin
            valid = 1'b1;
        end else if (code < CODE_LIMIT) begin
            case (base)
                C_RUN, C_SPEED, C_STALL, C_THRESH, C_REGEN, C_THERM,
                C_READY, C_OVERC, C_UNDERC, C_FBLOW, C_FBHIGH, C_LOOPDIR,
                C_BLOWER, C_HEAT, C_PLDEC, C_LOOPON, C_RETRY, C_PAUSE,
                C_LIFE, C_FAULT3, C_MAINT, C_REMOTE, C_ALARM, C_FAULT: begin
                    valid = 1'b1;
                end
                C_AVGPLS: begin
                    valid = !IS_RELAY;
                end
                default: begin
                    valid = 1'b0;
                end
            endcase
        end
    end
endmodule // osts_code_check

// ===== design/osts_top.sv
// routes drive status indications to the open-collector and relay terminals
// assumes status inputs synchronous to clk and a one-cycle-latency register port
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ns
module osts_top #(
    parameter int TICK_CYCLES = osts_pkg::HOLD_UNIT_NS / osts_pkg::CLK_PERIOD_NS  // per ms
) (
    input  wire logic                            clk,               // 50 MHz clock
    input  wire logic                            arst_n,            // async reset, low
    input  wire logic [osts_pkg::ADR_W-1:0]      regAddr,           // register address
    input  wire logic [osts_pkg::DAT_W-1:0]      regWrData,         // write data
    input  wire logic                            regWr,             // write strobe
    input  wire logic                            regRd,             // read strobe
    output logic      [osts_pkg::DAT_W-1:0]      regRdData,         // read data, next cycle
    input  wire logic [osts_pkg::SEL_W-1:0]      extendedDisplaySelect, // lock when nonzero
    input  wire logic                            driveOperating,    // drive in operation
    input  wire logic [osts_pkg::VAL_W-1:0]      outputFreq,        // output frequency
    input  wire logic [osts_pkg::VAL_W-1:0]      startSpeedFloor,   // starting frequency
    input  wire logic                            targetSpeedReached, // speed reached
    input  wire logic                            stallGuardActive,  // stall prevention on
    input  wire logic [osts_pkg::VAL_W-1:0]      fwdThreshold,      // forward threshold
    input  wire logic [osts_pkg::VAL_W-1:0]      revThreshold,      // reverse threshold
    input  wire logic                            reverseRotation,   // rotating in reverse
    input  wire logic [osts_pkg::VAL_W-1:0]      regenDuty,         // accumulated regen duty
    input  wire logic [osts_pkg::VAL_W-1:0]      regenDutyLimit,    // regen duty limit
    input  wire logic [osts_pkg::VAL_W-1:0]      thermalValue,      // thermal model value
    input  wire logic [osts_pkg::VAL_W-1:0]      thermalTripLevel,  // thermal trip level
    input  wire logic                            driveReadyFlag,    // drive ready
    input  wire logic                            currentAboveLimit, // current over threshold
    input  wire logic                            quantityBelowLimit, // quantity under threshold
    input  wire logic                            feedbackBelowFloor, // feedback under floor
    input  wire logic                            feedbackAboveCeiling, // feedback over ceiling
    input  wire logic                            loopForwardDirection, // loop commands forward
    input  wire logic                            blowerFault,       // cooling blower fault
    input  wire logic [osts_pkg::VAL_W-1:0]      heatsinkTemp,      // heatsink temperature
    input  wire logic [osts_pkg::VAL_W-1:0]      overheatTemp,      // overheat protection temp
    input  wire logic                            powerlossDecelStart, // decel function starts
    input  wire logic                            powerlossRelease,  // decel function released
    input  wire logic                            closedLoopActive,  // closed loop in effect
    input  wire logic                            retryActiveFlag,   // fault retry running
    input  wire logic                            loopOutputPaused,  // loop output interrupted
    input  wire logic                            lifeAlarm,         // service life alarm
    input  wire logic                            internalFault,     // circuit fault output
    input  wire logic                            currentAvgPulse,   // average current pulses
    input  wire logic                            maintenanceDue,    // maintenance timer
    input  wire logic                            remoteOutput,      // remote output bit
    input  wire logic                            alarmOutput,       // minor alarm
    input  wire logic                            faultRelaySignal,  // fault present
    output logic                                 collectorOut,      // open collector conducts
    output logic                                 relayOut,          // relay contact closed
    output logic                                 thermalTrip        // thermal trip at 100 pct
);
    import osts_pkg::*;

    localparam int TICK_W = $clog2(TICK_CYCLES + 1);
    localparam int PROD_W = VAL_W + 8;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
    localparam int TERMS = 2;

    typedef struct packed {
        logic [SEL_W-1:0]  collSel;
        logic [SEL_W-1:0]  relaySel;
        logic [DAT_W-1:0]  ocHold;
        logic [DAT_W-1:0]  ucHold;
        logic [TICK_W-1:0] tickCnt;
        logic [DAT_W-1:0]  ocCnt;
        logic [DAT_W-1:0]  ucCnt;
        logic              ocFlag;
        logic              ucFlag;
        logic              plLatch;
        logic              rejected;
        logic [DAT_W-1:0]  rdData;
        logic              collectorOut;
        logic              relayOut;
        logic              thermalTrip;
    } osts_state_type;

    osts_state_type state;
    osts_state_type next_state;

    logic [TERMS-1:0] codeOk;
    logic             msTick;
    logic             runInd;
    logic             threshHit;
    logic             regenWarn;
    logic             thermWarn;
    logic             thermAtTrip;
    logic             heatWarn;
    logic [PROD_W-1:0] regenScaled;
    logic [PROD_W-1:0] regenBound;
    logic [PROD_W-1:0] thermScaled;
    logic [PROD_W-1:0] thermBound;
    logic [PROD_W-1:0] thermFull;
    logic [PROD_W-1:0] heatScaled;
    logic [PROD_W-1:0] heatBound;

    // one checker per terminal; the relay instance refuses the pulse code
    genvar t;
    generate
        for (t = 0; t < TERMS; t++) begin : g_check
            osts_code_check #(
                .IS_RELAY (t == 1)
            ) u_check (
                .code  (regWrData),
                .valid (codeOk[t])
            );
        end
    endgenerate

    // indication for one stored code, then polarity applied
    function automatic logic drive_terminal(input logic [SEL_W-1:0] sel,
                                            input logic [63:0]      ind);
        logic [SEL_W-1:0] base;
        logic             hit;
        base = (sel >= NEG_OFFSET) ? sel - NEG_OFFSET : sel;
        hit  = 1'b0;
        case (base)
            C_RUN:     hit = ind[0];
            C_SPEED:   hit = ind[1];
            C_STALL:   hit = ind[2];
            C_THRESH:  hit = ind[3];
            C_REGEN:   hit = ind[4];
            C_THERM:   hit = ind[5];
            C_READY:   hit = ind[6];
            C_OVERC:   hit = ind[7];
            C_UNDERC:  hit = ind[8];
            C_FBLOW:   hit = ind[9];
            C_FBHIGH:  hit = ind[10];
            C_LOOPDIR: hit = ind[11];
            C_BLOWER:  hit = ind[12];
            C_HEAT:    hit = ind[13];
            C_PLDEC:   hit = ind[14];
            C_LOOPON:  hit = ind[15];
            C_RETRY:   hit = ind[16];
            C_PAUSE:   hit = ind[17];
            C_LIFE:    hit = ind[18];
            C_FAULT3:  hit = ind[19];
            C_AVGPLS:  hit = ind[20];
            C_MAINT:   hit = ind[21];
            C_REMOTE:  hit = ind[22];
            C_ALARM:   hit = ind[23];
            C_FAULT:   hit = ind[24];
            default:   hit = 1'b0;
        endcase
        // no-function code never conducts
        if (sel == NO_FUNC) begin
            drive_terminal = 1'b0;
        end else if (sel >= NEG_OFFSET) begin
            drive_terminal = !hit;
        end else begin
            drive_terminal = hit;
        end
    endfunction

    logic [63:0] ind;

    always_comb begin
        msTick      = (state.tickCnt == TICK_LAST);
        runInd      = driveOperating && (outputFreq >= startSpeedFloor);
        threshHit   = reverseRotation ? (outputFreq >= revThreshold)
                                      : (outputFreq >= fwdThreshold);
        // products scaled so the compare is exact without division
        regenScaled = PROD_W'(regenDuty) * PROD_W'(PCT_FULL);
        regenBound  = PROD_W'(regenDutyLimit) * PROD_W'(PCT_WARN);
        regenWarn   = (regenScaled >= regenBound);
        thermScaled = PROD_W'(thermalValue) * PROD_W'(PCT_FULL);
        thermBound  = PROD_W'(thermalTripLevel) * PROD_W'(PCT_WARN);
        thermFull   = PROD_W'(thermalTripLevel) * PROD_W'(PCT_FULL);
        thermWarn   = (thermScaled >= thermBound);
        thermAtTrip = (thermScaled >= thermFull);
        heatScaled  = PROD_W'(heatsinkTemp) * PROD_W'(PCT_FULL);
        heatBound   = PROD_W'(overheatTemp) * PROD_W'(PCT_WARN);
        heatWarn    = (heatScaled >= heatBound);
        ind         = '0;
        ind[0]      = runInd;
        ind[1]      = targetSpeedReached;
        ind[2]      = stallGuardActive;
        ind[3]      = threshHit;
        ind[4]      = regenWarn;
        ind[5]      = thermWarn;
        ind[6]      = driveReadyFlag;
        ind[7]      = state.ocFlag;
        ind[8]      = state.ucFlag;
        ind[9]      = feedbackBelowFloor;
        ind[10]     = feedbackAboveCeiling;
        ind[11]     = loopForwardDirection;
        ind[12]     = blowerFault;
        ind[13]     = heatWarn;
        ind[14]     = state.plLatch;
        ind[15]     = closedLoopActive;
        ind[16]     = retryActiveFlag;
        ind[17]     = loopOutputPaused;
        ind[18]     = lifeAlarm;
        ind[19]     = internalFault;
        ind[20]     = currentAvgPulse;
        ind[21]     = maintenanceDue;
        ind[22]     = remoteOutput;
        ind[23]     = alarmOutput;
        ind[24]     = faultRelaySignal;
    end

    always_comb begin
        next_state         = state;
        next_state.tickCnt = msTick ? '0 : state.tickCnt + TICK_W'(1);

        // hold filters count whole milliseconds; a drop restarts them
        if (!currentAboveLimit) begin
            next_state.ocCnt  = '0;
            next_state.ocFlag = 1'b0;
        end else if (msTick) begin
            if (state.ocCnt > state.ocHold) begin
                next_state.ocFlag = 1'b1;
            end else begin
                next_state.ocCnt = state.ocCnt + DAT_W'(1);
            end
        end
        if (!quantityBelowLimit) begin
            next_state.ucCnt  = '0;
            next_state.ucFlag = 1'b0;
        end else if (msTick) begin
            if (state.ucCnt > state.ucHold) begin
                next_state.ucFlag = 1'b1;
            end else begin
                next_state.ucCnt = state.ucCnt + DAT_W'(1);
            end
        end

        // start wins over release arriving in the same cycle
        if (powerlossDecelStart) begin
            next_state.plLatch = 1'b1;
        end else if (powerlossRelease) begin
            next_state.plLatch = 1'b0;
        end

        if (regWr) begin
            if (regAddr == ADDR_COLL_SEL) begin
                if (extendedDisplaySelect == '0 && codeOk[0]) begin
                    next_state.collSel  = regWrData;
                    next_state.rejected = 1'b0;
                end else begin
                    next_state.rejected = 1'b1;
                end
            end else if (regAddr == ADDR_RELAY_SEL) begin
                if (extendedDisplaySelect == '0 && codeOk[1]) begin
                    next_state.relaySel = regWrData;
                    next_state.rejected = 1'b0;
                end else begin
                    next_state.rejected = 1'b1;
                end
            end else if (regAddr == ADDR_OC_HOLD) begin
                next_state.ocHold = regWrData;
            end else if (regAddr == ADDR_UC_HOLD) begin
                next_state.ucHold = regWrData;
            end
        end

        next_state.rdData = '0;
        if (regRd) begin
            if (regAddr == ADDR_COLL_SEL) begin
                next_state.rdData = state.collSel;
            end else if (regAddr == ADDR_RELAY_SEL) begin
                next_state.rdData = state.relaySel;
            end else if (regAddr == ADDR_OC_HOLD) begin
                next_state.rdData = state.ocHold;
            end else if (regAddr == ADDR_UC_HOLD) begin
                next_state.rdData = state.ucHold;
            end else if (regAddr == ADDR_STATUS) begin
                next_state.rdData[ST_COLL]   = state.collectorOut;
                next_state.rdData[ST_RELAY]  = state.relayOut;
                next_state.rdData[ST_TRIP]   = state.thermalTrip;
                next_state.rdData[ST_REJECT] = state.rejected;
            end
        end

        next_state.collectorOut = drive_terminal(state.collSel, ind);
        next_state.relayOut     = drive_terminal(state.relaySel, ind);
        next_state.thermalTrip  = thermAtTrip;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state          <= '0;
            state.collSel  <= COLL_SEL_RST;
            state.relaySel <= RELAY_SEL_RST;
            state.ocHold   <= HOLD_RST;
            state.ucHold   <= HOLD_RST;
        end else begin
            state <= next_state;
        end
    end

    assign regRdData    = state.rdData;
    assign collectorOut = state.collectorOut;
    assign relayOut     = state.relayOut;
    assign thermalTrip  = state.thermalTrip;
endmodule // osts_top

// ===== tb/osts_props.sv
// assertion checker for the output terminal selector
// sees only osts_top ports; bound at the foot of this file
`timescale 1ns/1ns
module osts_props
    import osts_pkg::*;
(
    input wire logic             clk,                   // clock
    input wire logic             arst_n,                // reset, low
    input wire logic [ADR_W-1:0] regAddr,               // address
    input wire logic [DAT_W-1:0] regWrData,             // write data
    input wire logic             regWr,                 // write strobe
    input wire logic             regRd,                 // read strobe
    input wire logic [DAT_W-1:0] regRdData,             // read data
    input wire logic [SEL_W-1:0] extendedDisplaySelect, // lock
    input wire logic             driveOperating,        // running
    input wire logic [VAL_W-1:0] outputFreq,            // frequency
    input wire logic [VAL_W-1:0] startSpeedFloor,       // start floor
    input wire logic             faultRelaySignal,      // fault
    input wire logic [VAL_W-1:0] thermalValue,          // thermal value
    input wire logic [VAL_W-1:0] thermalTripLevel,      // trip level
    input wire logic             collectorOut,          // collector
    input wire logic             relayOut,              // relay
    input wire logic             thermalTrip            // trip
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // defaults only hold until software writes a register
    logic wrote;
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n) wrote <= 1'b0;
        else if (regWr) wrote <= 1'b1;
    rst_coll_a: assert property (
        !wrote && regRd && regAddr == ADDR_COLL_SEL |=> regRdData == COLL_SEL_RST)
        else $error("collector select reset value wrong");
    rst_relay_a: assert property (
        !wrote && regRd && regAddr == ADDR_RELAY_SEL |=> regRdData == RELAY_SEL_RST)
        else $error("relay select reset value wrong");
    dflt_coll_a: assert property (!wrote && $past(arst_n) |->
        collectorOut == $past(driveOperating && outputFreq >= startSpeedFloor))
        else $error("collector default routing wrong");
    dflt_relay_a: assert property (
        !wrote && $past(arst_n) |-> relayOut == $past(faultRelaySignal))
        else $error("relay default routing wrong");
    lock_rej_a: assert property ((regWr && regAddr <= ADDR_RELAY_SEL &&
        extendedDisplaySelect != 0) ##1 (regRd && regAddr == ADDR_STATUS) |=> regRdData[3])
        else $error("locked write not refused");
    relay_pulse_a: assert property ((regWr && regAddr == ADDR_RELAY_SEL &&
        regWrData == C_AVGPLS) ##1 (regRd && regAddr == ADDR_STATUS) |=> regRdData[3])
        else $error("relay took pulse code");
    bad_code_a: assert property ((regWr && regAddr == ADDR_COLL_SEL &&
        regWrData == 16'h0002) ##1 (regRd && regAddr == ADDR_STATUS) |=> regRdData[3])
        else $error("unlisted code not refused");
    none_ok_a: assert property ((regWr && regAddr == ADDR_RELAY_SEL &&
        regWrData == NO_FUNC && extendedDisplaySelect == 0) ##1
        (regRd && regAddr == ADDR_RELAY_SEL) |=> regRdData == NO_FUNC)
        else $error("no-function code refused");
    trip_lvl_a: assert property (
        $past(arst_n) |-> thermalTrip == $past(thermalValue >= thermalTripLevel))
        else $error("thermal trip level wrong");
endmodule // osts_props

bind osts_top osts_props osts_props_inst (.clk, .arst_n, .regAddr, .regWrData, .regWr,
    .regRd, .regRdData, .extendedDisplaySelect, .driveOperating, .outputFreq,
    .startSpeedFloor, .faultRelaySignal, .thermalValue, .thermalTripLevel,
    .collectorOut, .relayOut, .thermalTrip);

// ===== tb/osts_partner.sv
// model of the drive control core feeding the status indications
// assumes one clock; every indication changes just after each edge
`timescale 1ns/1ns
module osts_partner (
    input  wire logic   clk,       // clock
    input  wire logic   arst_n,    // reset, low
    output logic [22:0] flags,     // one-bit indications
    output logic [15:0] vals [10]  // quantities
);
    // small quantities keep the percent compares flipping both ways
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flags <= '0;
            foreach (vals[i]) vals[i] <= '0;
        end else begin
            flags <= 23'($urandom);
            foreach (vals[i]) vals[i] <= 16'($urandom_range(0, 20));
        end
    end
endmodule // osts_partner

// ===== tb/osts_tb_top.sv
// self-checking bench for the output terminal selector
// assumes the partner core drives every status input at random
`timescale 1ns/1ns
module osts_tb_top;
    import osts_pkg::*;
    logic             clk, arst_n, regWr, regRd, collectorOut, relayOut, thermalTrip;
    logic [ADR_W-1:0] regAddr;
    logic [DAT_W-1:0] regWrData, regRdData, eds, rv;
    logic [22:0]      b;
    logic [15:0]      v [10];
    int               errors, comparisons, cyc;
    int               codes [18] = '{0, 1, 3, 4, 7, 8, 11, 12, 13, 14, 15, 16, 25, 26, 46,
                                     47, 64, 70};
    int               tk, oc, uc;
    logic             ocf, ucf, pl;
    osts_partner osts_partner_inst (.clk, .arst_n, .flags(b), .vals(v));
    osts_top #(.TICK_CYCLES(4)) osts_top_inst (.clk, .arst_n, .regAddr, .regWrData,
        .regWr, .regRd, .regRdData, .extendedDisplaySelect(eds), .driveOperating(b[0]),
        .outputFreq(v[0]), .startSpeedFloor(v[1]), .targetSpeedReached(b[1]),
        .stallGuardActive(b[2]), .fwdThreshold(v[2]), .revThreshold(v[3]),
        .reverseRotation(b[3]), .regenDuty(v[4]), .regenDutyLimit(v[5]),
        .thermalValue(v[6]), .thermalTripLevel(v[7]), .driveReadyFlag(b[4]),
        .currentAboveLimit(b[5]), .quantityBelowLimit(b[6]), .feedbackBelowFloor(b[7]),
        .feedbackAboveCeiling(b[8]), .loopForwardDirection(b[9]), .blowerFault(b[10]),
        .heatsinkTemp(v[8]), .overheatTemp(v[9]), .powerlossDecelStart(b[11]),
        .powerlossRelease(b[12]), .closedLoopActive(b[13]), .retryActiveFlag(b[14]),
        .loopOutputPaused(b[15]), .lifeAlarm(b[16]), .internalFault(b[17]),
        .currentAvgPulse(b[18]), .maintenanceDue(b[19]), .remoteOutput(b[20]),
        .alarmOutput(b[21]), .faultRelaySignal(b[22]), .collectorOut, .relayOut,
        .thermalTrip);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            errors++;
            stop_test();
        end
    end
    // reference for hold filters (holds stay at reset value) and power-loss latch
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {tk, oc, uc, ocf, ucf, pl} <= '0;
        end else begin
            tk <= (tk + 1) % 4;
            ocf <= b[5] && (ocf || (tk == 3 && oc > HOLD_RST));
            oc <= !b[5] ? 0 : oc + int'(tk == 3 && oc <= HOLD_RST);
            ucf <= b[6] && (ucf || (tk == 3 && uc > HOLD_RST));
            uc <= !b[6] ? 0 : uc + int'(tk == 3 && uc <= HOLD_RST);
            if (b[11]) pl <= 1'b1;
            else if (b[12]) pl <= 1'b0;
        end
    end
    task automatic stop_test();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // one bus cycle; read data is captured in the cycle after the strobe
    task automatic acc(logic w, logic [3:0] a, logic [15:0] d);
        regWr <= w;
        regRd <= !w;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
        regRd <= 1'b0;
        #1 rv = regRdData;
    endtask
    task automatic rej(logic [3:0] a, logic [15:0] d, logic [15:0] keep);
        acc(1'b1, a, d);
        acc(1'b0, ADDR_STATUS, '0);
        chk("reject flag", 16'h0001, 16'(rv[ST_REJECT]));
        acc(1'b0, a, '0);
        chk("select kept", keep, rv);
    endtask
    function automatic logic ex(int c);
        logic x;
        case (c % 100)
            0: x = b[0] && v[0] >= v[1];
            1: x = b[1];
            3: x = b[2];
            4: x = v[0] >= (b[3] ? v[3] : v[2]);
            7: x = v[4] * 100 >= v[5] * 85;
            8: x = v[6] * 100 >= v[7] * 85;
            11: x = b[4];
            12: x = ocf;
            13: x = ucf;
            46: x = pl;
            14: x = b[7];
            15: x = b[8];
            16: x = b[9];
            25: x = b[10];
            26: x = v[8] * 100 >= v[9] * 85;
            47: x = b[13];
            64: x = b[14];
            70: x = b[15];
            default: x = 1'b0;
        endcase
        return c == 9999 ? 1'b0 : (c >= 100 ? !x : x);
    endfunction
    task automatic run(int c);
        logic e;
        repeat (6) begin
            @(negedge clk);
            e = ex(c);
            @(posedge clk);
            #1 chk("collector", 16'(e), 16'(collectorOut));
            chk("relay", 16'(e), 16'(relayOut));
        end
    endtask
    initial begin
        void'($urandom(14));
        {regWr, regRd, regAddr, regWrData, eds, errors, comparisons, cyc} = '0;
        arst_n = 1'b0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        acc(1'b0, ADDR_COLL_SEL, '0);
        chk("collector select", COLL_SEL_RST, rv);
        acc(1'b0, ADDR_RELAY_SEL, '0);
        chk("relay select", RELAY_SEL_RST, rv);
        foreach (codes[i]) for (int p = 0; p < 2; p++) begin
            acc(1'b1, ADDR_COLL_SEL, 16'(codes[i] + 100 * p));
            acc(1'b1, ADDR_RELAY_SEL, 16'(codes[i] + 100 * p));
            acc(1'b0, ADDR_RELAY_SEL, '0);
            chk("relay select", 16'(codes[i] + 100 * p), rv);
            run(codes[i] + 100 * p);
        end
        acc(1'b1, ADDR_RELAY_SEL, NO_FUNC);
        acc(1'b0, ADDR_RELAY_SEL, '0);
        chk("relay select", NO_FUNC, rv);
        acc(1'b1, ADDR_COLL_SEL, NO_FUNC);
        run(9999);
        acc(1'b1, ADDR_COLL_SEL, C_AVGPLS);
        acc(1'b0, ADDR_COLL_SEL, '0);
        chk("collector select", C_AVGPLS, rv);
        rej(ADDR_RELAY_SEL, C_AVGPLS, NO_FUNC);
        rej(ADDR_COLL_SEL, 16'h0002, C_AVGPLS);
        eds <= 16'($urandom_range(1, 65535));
        rej(ADDR_RELAY_SEL, C_READY, NO_FUNC);
        eds <= '0;
        acc(1'b1, ADDR_RELAY_SEL, C_READY + NEG_OFFSET);
        acc(1'b0, ADDR_RELAY_SEL, '0);
        chk("relay select", C_READY + NEG_OFFSET, rv);
        acc(1'b0, 4'hF, '0);
        chk("unmapped read", 16'h0000, rv);
        stop_test();
    end
endmodule // osts_tb_top
